// [hw/ppb_an_fsm.sv]
// Access-side port status FSM for a telephony user port, with its line-signal gate.
//
// Notes on behaviour
// (RQ1) Four states: blocked, local, remote unblock, operational.
// (RQ2) Report entering operational, and leaving it; leaving on a management block gives management no report.
// (RQ3) Deferrable block request only when operational.
// (RQ4) Non-operational: call entity blocked, no line signals.
// (RQ5) Unblock acknowledged; immediate block is unacknowledged.
// (RQ6) No timeout in either unblock state.
// (RQ7) Management block: send block, go blocked.
// (RQ8) Exchange management block sends its block command.
// (RQ9) Exchange block received: report block, go blocked.
// (RQ10) Deferrable request sent; exchange passes it on.
// (RQ11) Exchange grants request by blocking the port.
// (RQ12) Unblock request withdraws a pending deferrable request.
// (RQ13) Exchange unblock: enter remote unblock, ask management.
// (RQ14) Agreement in remote unblock: acknowledge, go operational.
// (RQ15) Exchange goes operational on our acknowledgement.
// (RQ16) Either side may start the co-ordinated unblock.
// (RQ17) Peer block in remote unblock cancels unblocking.
// (RQ18) Unblock request action depends on current state.
// (RQ19) Unblock request also checks operational status locally.
// (RQ20) Exchange unblock request handling per its state.
// (RQ21) Exchange status check answered over the link.
// (RQ22) Unexpected events are ignored, state kept.
// (RQ23) Five messages carried as distinct codes.
`timescale 1ns/1ns
`default_nettype none

module ppb_an_fsm (
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              rst,
   // Primitives from management, one-cycle pulses.
   input  wire logic              mgmt_unblock_request,
   input  wire logic              mgmt_block_command,
   input  wire logic              mgmt_deferrable_block_request,
   // Primitives to management.
   output var  ppb_pkg::ppb_mgmt_out_t mgmt_out,
   // Signalling link from and to the exchange.
   input  wire ppb_pkg::ppb_link_t rx,
   output var  ppb_pkg::ppb_link_t tx,
   // Line signals from the port and towards the exchange.
   input  wire ppb_pkg::ppb_line_t line_in,
   output var  ppb_pkg::ppb_line_t line_out,
   // Port status.
   output var  logic              access_call_entity_blocked,
   output var  logic              port_operational,
   output var  ppb_pkg::ppb_state_t port_state
);

   ppb_pkg::ppb_regs_t r;
   ppb_pkg::ppb_regs_t next_r;
   ppb_pkg::ppb_event_t ev;

   // True when the link word is valid and carries the given message.
   function automatic logic rx_is(input ppb_pkg::ppb_link_t m, input ppb_pkg::ppb_msg_t c);
      return m.valid && (m.code == c);
   endfunction : rx_is

   // Pick one event per cycle; an immediate block outranks all else.
   always_comb begin
      if (mgmt_block_command) begin
         ev = ppb_pkg::ev_mgmt_block;
      end else if (rx_is(rx, ppb_pkg::le_block_cmd_msg)) begin
         ev = ppb_pkg::ev_rx_block;
      end else if (rx_is(rx, ppb_pkg::le_unblock_msg)) begin
         ev = ppb_pkg::ev_rx_unblock;
      end else if (mgmt_unblock_request) begin
         ev = ppb_pkg::ev_mgmt_unblock;
      end else if (mgmt_deferrable_block_request) begin
         ev = ppb_pkg::ev_mgmt_blkreq;
      end else begin
         ev = ppb_pkg::ev_none;
      end
   end

   // Transition table; every pulse output defaults low each cycle.
   always_comb begin
      next_r = r;
      next_r.tx.valid = 1'b0;
      next_r.tx.code = ppb_pkg::msg_none; // [RQ23]
      next_r.mgmt = '0;
      case (ev)
         ppb_pkg::ev_mgmt_block: begin
            // Sent from every state, no answer awaited. [RQ7] [RQ5]
            next_r.tx.valid = 1'b1;
            next_r.tx.code = ppb_pkg::an_block_cmd_msg;
            next_r.state = ppb_pkg::access_blocked_state;
         end
         ppb_pkg::ev_rx_block: begin
            // Already blocked: nothing to report. [RQ9] [RQ17] [RQ11]
            if (r.state != ppb_pkg::access_blocked_state) begin
               next_r.mgmt.block_command = 1'b1; // [RQ2]
               next_r.state = ppb_pkg::access_blocked_state;
            end
         end
         ppb_pkg::ev_rx_unblock: begin
            case (r.state)
               ppb_pkg::access_blocked_state: begin
                  // Exchange starts unblocking; ask management. [RQ13] [RQ16]
                  next_r.mgmt.unblock_request = 1'b1;
                  next_r.state = ppb_pkg::access_remote_unblock_state;
               end
               ppb_pkg::access_local_unblock_state: begin
                  // Our own unblock is acknowledged. [RQ16] [RQ5]
                  next_r.mgmt.unblock_indication = 1'b1;
                  next_r.state = ppb_pkg::access_operational_state;
               end
               ppb_pkg::access_remote_unblock_state: begin
                  // Repeated request, ask management again. [RQ13]
                  next_r.mgmt.unblock_request = 1'b1;
               end
               default: begin
                  // Exchange status check answered over the link. [RQ21]
                  next_r.tx.valid = 1'b1;
                  next_r.tx.code = ppb_pkg::an_unblock_msg;
                  next_r.mgmt.unblock_indication = 1'b1;
               end
            endcase
         end
         ppb_pkg::ev_mgmt_unblock: begin
            // Unblock request from management, per state. [RQ18]
            next_r.tx.valid = 1'b1;
            next_r.tx.code = ppb_pkg::an_unblock_msg;
            case (r.state)
               ppb_pkg::access_blocked_state: begin
                  next_r.state = ppb_pkg::access_local_unblock_state;
               end
               ppb_pkg::access_local_unblock_state: begin
                  next_r.state = r.state;
               end
               ppb_pkg::access_remote_unblock_state: begin
                  // Agreement with the exchange's unblock. [RQ14]
                  next_r.mgmt.unblock_indication = 1'b1;
                  next_r.state = ppb_pkg::access_operational_state;
               end
               default: begin
                  // Local status answer; also withdraws a request. [RQ19] [RQ12]
                  next_r.mgmt.unblock_indication = 1'b1;
               end
            endcase
         end
         ppb_pkg::ev_mgmt_blkreq: begin
            // Deferrable request goes out only when operational. [RQ3] [RQ10]
            if (r.state == ppb_pkg::access_operational_state) begin
               next_r.tx.valid = 1'b1;
               next_r.tx.code = ppb_pkg::an_block_request_msg;
            end
         end
         default: begin
            // No event; unblock states wait without limit. [RQ6] [RQ22]
            next_r.state = r.state;
         end
      endcase
      // Status and call-entity blocking follow the next state. [RQ1] [RQ4]
      next_r.operational = (next_r.state == ppb_pkg::access_operational_state);
      next_r.call_blocked = !next_r.operational;
      // Line signals pass only while operational now and next. [RQ4]
      next_r.line.valid = line_in.valid && r.operational && next_r.operational;
      next_r.line.data = next_r.line.valid ? line_in.data : '0;
   end

   // State register; reset lands in blocked with all pulses low.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r.state <= ppb_pkg::access_blocked_state;
         r.tx.valid <= 1'b0;
         r.tx.code <= ppb_pkg::msg_none;
         r.mgmt <= '0;
         r.line <= '0;
         r.call_blocked <= 1'b1;
         r.operational <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register.
   assign mgmt_out = r.mgmt;
   assign tx = r.tx;
   assign line_out = r.line;
   assign access_call_entity_blocked = r.call_blocked;
   assign port_operational = r.operational;
   assign port_state = r.state;

   // Management block always yields a block message and blocked state.
   property p_mgmt_block;
      @(posedge clk) disable iff (rst)
      mgmt_block_command |=> tx.valid && tx.code == ppb_pkg::an_block_cmd_msg
         && port_state == ppb_pkg::access_blocked_state && !mgmt_out.block_command;
   endproperty
   a_mgmt_block: assert property (p_mgmt_block) else $error("block not sent"); // [RQ7]

   // Received block outside blocked is reported and blocks the port.
   property p_rx_block;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_rx_block && port_state != ppb_pkg::access_blocked_state
         |=> mgmt_out.block_command && port_state == ppb_pkg::access_blocked_state
         && !tx.valid;
   endproperty
   a_rx_block: assert property (p_rx_block) else $error("peer block missed"); // [RQ9]

   // A deferrable request is only ever sent from operational.
   property p_blkreq;
      @(posedge clk) disable iff (rst)
      tx.valid && tx.code == ppb_pkg::an_block_request_msg
         |-> $past(port_state) == ppb_pkg::access_operational_state;
   endproperty
   a_blkreq: assert property (p_blkreq) else $error("request outside operation"); // [RQ3]

   // No line signals and call entity blocked when not operational.
   property p_gate;
      @(posedge clk) disable iff (rst)
      port_state != ppb_pkg::access_operational_state
         |-> !line_out.valid && access_call_entity_blocked && !port_operational;
   endproperty
   a_gate: assert property (p_gate) else $error("line passed while blocked"); // [RQ4]

   // Agreement in remote unblock acknowledges and goes operational.
   property p_agree;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_mgmt_unblock && port_state == ppb_pkg::access_remote_unblock_state
         |=> port_operational && mgmt_out.unblock_indication
         && tx.code == ppb_pkg::an_unblock_msg
         ##1 (!port_operational || line_out.valid == $past(line_in.valid));
   endproperty
   a_agree: assert property (p_agree) else $error("agreement not completed"); // [RQ14]

   // Unblock request in blocked starts a local unblock.
   property p_local;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_mgmt_unblock && port_state == ppb_pkg::access_blocked_state
         |=> port_state == ppb_pkg::access_local_unblock_state && tx.valid
         && tx.code == ppb_pkg::an_unblock_msg && !mgmt_out.unblock_indication;
   endproperty
   a_local: assert property (p_local) else $error("local unblock not entered"); // [RQ18]

   // Entering operational is always reported.
   property p_enter;
      @(posedge clk) disable iff (rst)
      $rose(port_operational) |-> mgmt_out.unblock_indication;
   endproperty
   a_enter: assert property (p_enter) else $error("entry not reported"); // [RQ2]

   // Peer unblock in blocked leads to remote unblock and a request.
   property p_remote;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_rx_unblock && port_state == ppb_pkg::access_blocked_state
         |=> port_state == ppb_pkg::access_remote_unblock_state
         && mgmt_out.unblock_request && !tx.valid;
   endproperty
   a_remote: assert property (p_remote) else $error("remote unblock missed"); // [RQ13]

   // Peer block while blocked changes nothing and sends nothing.
   property p_ignore;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_rx_block && port_state == ppb_pkg::access_blocked_state
         |=> $stable(port_state) && !tx.valid && mgmt_out == '0;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored event acted"); // [RQ22]

   // A refused deferrable request leaves everything as it was.
   property p_refuse;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_mgmt_blkreq && port_state != ppb_pkg::access_operational_state
         |=> !tx.valid && $stable(port_state) && mgmt_out == '0;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused request acted"); // [RQ3]

   // Local status check while operational answers without leaving the state.
   property p_status;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_mgmt_unblock && port_state == ppb_pkg::access_operational_state
         |=> port_operational && tx.valid && tx.code == ppb_pkg::an_unblock_msg
         && mgmt_out.unblock_indication;
   endproperty
   a_status: assert property (p_status) else $error("status not answered"); // [RQ19]

   // Exchange status check while operational is answered over the link.
   property p_check;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_rx_unblock && port_state == ppb_pkg::access_operational_state
         |=> port_operational && tx.valid && tx.code == ppb_pkg::an_unblock_msg
         && mgmt_out.unblock_indication;
   endproperty
   a_check: assert property (p_check) else $error("check not answered"); // [RQ21]

   // Acknowledgement in local unblock goes operational without sending.
   property p_ack;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_rx_unblock && port_state == ppb_pkg::access_local_unblock_state
         |=> port_operational && mgmt_out.unblock_indication && !tx.valid;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge not taken"); // [RQ5]

   // A second unblock request in local unblock resends and keeps the state.
   property p_resend;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_mgmt_unblock && port_state == ppb_pkg::access_local_unblock_state
         |=> port_state == ppb_pkg::access_local_unblock_state && tx.valid
         && tx.code == ppb_pkg::an_unblock_msg && mgmt_out == '0;
   endproperty
   a_resend: assert property (p_resend) else $error("unblock not resent"); // [RQ18]

   // A repeated peer unblock in remote unblock asks management again.
   property p_repeat;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_rx_unblock && port_state == ppb_pkg::access_remote_unblock_state
         |=> port_state == ppb_pkg::access_remote_unblock_state
         && mgmt_out.unblock_request && !tx.valid;
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeat not passed on"); // [RQ13]

   // Leaving operational always comes with a block message or report.
   property p_leave;
      @(posedge clk) disable iff (rst)
      $fell(port_operational)
         |-> mgmt_out.block_command || (tx.valid && tx.code == ppb_pkg::an_block_cmd_msg);
   endproperty
   a_leave: assert property (p_leave) else $error("exit not reported"); // [RQ2]

   // With no event the state holds and nothing is sent, without limit.
   property p_wait;
      @(posedge clk) disable iff (rst)
      ev == ppb_pkg::ev_none
         |=> $stable(port_state) && !tx.valid && mgmt_out == '0;
   endproperty
   a_wait: assert property (p_wait) else $error("state moved on its own"); // [RQ6]

   // An idle link output carries the empty code.
   property p_tx_idle;
      @(posedge clk) disable iff (rst)
      !tx.valid |-> tx.code == ppb_pkg::msg_none;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("idle code not empty"); // [RQ23]

   // A line word that is not forwarded shows zero data.
   property p_line_zero;
      @(posedge clk) disable iff (rst)
      !line_out.valid |-> line_out.data == '0;
   endproperty
   a_line_zero: assert property (p_line_zero) else $error("dropped line data shown"); // [RQ4]

   // Main scenarios.
   c_remote_up: cover property (@(posedge clk) disable iff (rst)
      port_state == ppb_pkg::access_remote_unblock_state ##1 port_operational);
   c_local_up: cover property (@(posedge clk) disable iff (rst)
      port_state == ppb_pkg::access_local_unblock_state ##1 port_operational);
   c_blkreq: cover property (@(posedge clk) disable iff (rst)
      tx.valid && tx.code == ppb_pkg::an_block_request_msg);
   c_drop: cover property (@(posedge clk) disable iff (rst)
      $fell(port_operational) && mgmt_out.block_command);

endmodule : ppb_an_fsm

`default_nettype wire

// [hw/ppb_pkg.sv]
// Package with message codes, states, events and carriers for the access-side port FSM.
package ppb_pkg;

   // Width of one message code on the signalling link.
   localparam int unsigned MSG_W = 3;
   // Width of one line-signal word passed towards the exchange.
   localparam int unsigned LINE_W = 8;

   // Message codes, one distinct code per port-control message.
   localparam logic [MSG_W-1:0] CODE_NONE       = 3'h0;
   localparam logic [MSG_W-1:0] CODE_LE_UNBLOCK = 3'h1;
   localparam logic [MSG_W-1:0] CODE_AN_UNBLOCK = 3'h2;
   localparam logic [MSG_W-1:0] CODE_LE_BLOCK   = 3'h3;
   localparam logic [MSG_W-1:0] CODE_AN_BLOCK   = 3'h4;
   localparam logic [MSG_W-1:0] CODE_AN_BLKREQ  = 3'h5;

   typedef enum logic [MSG_W-1:0] {
      le_unblock_msg       = CODE_LE_UNBLOCK,
      an_unblock_msg       = CODE_AN_UNBLOCK,
      le_block_cmd_msg     = CODE_LE_BLOCK,
      an_block_cmd_msg     = CODE_AN_BLOCK,
      an_block_request_msg = CODE_AN_BLKREQ,
      msg_none             = CODE_NONE
   } ppb_msg_t;

   // Port states of the access side.
   typedef enum logic [1:0] {
      access_blocked_state,
      access_local_unblock_state,
      access_remote_unblock_state,
      access_operational_state
   } ppb_state_t;

   // The one event handled in a cycle, after precedence.
   typedef enum logic [2:0] {
      ev_none,
      ev_mgmt_block,
      ev_rx_block,
      ev_rx_unblock,
      ev_mgmt_unblock,
      ev_mgmt_blkreq
   } ppb_event_t;

   // One message on the signalling link.
   typedef struct packed {
      logic     valid;
      ppb_msg_t code;
   } ppb_link_t;

   // One line-signal word.
   typedef struct packed {
      logic              valid;
      logic [LINE_W-1:0] data;
   } ppb_line_t;

   // Primitives from the FSM to its management, one-cycle pulses.
   typedef struct packed {
      logic unblock_request;
      logic unblock_indication;
      logic block_command;
   } ppb_mgmt_out_t;

   // Complete state of the FSM module.
   typedef struct packed {
      ppb_state_t    state;
      ppb_link_t     tx;
      ppb_mgmt_out_t mgmt;
      ppb_line_t     line;
      logic          call_blocked;
      logic          operational;
   } ppb_regs_t;

endpackage : ppb_pkg

// [testbench/ppb_le_model.sv]
// Behavioural exchange-side port FSM that faces the access-side block.
`timescale 1ns/1ns
`default_nettype none

module ppb_le_model (
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Management primitives of the exchange.
   input  wire logic                   mgmt_unblock_request,
   input  wire logic                   mgmt_block_command,
   output var  ppb_pkg::ppb_mgmt_out_t mgmt_out,
   output var  logic                   blkreq,
   // Link to and from the access side.
   input  wire ppb_pkg::ppb_link_t     rx,
   output var  ppb_pkg::ppb_link_t     tx,
   // Exchange port state, in the same four encodings as the access side.
   output var  ppb_pkg::ppb_state_t    state
);
   localparam ppb_pkg::ppb_state_t blk = ppb_pkg::access_blocked_state;
   localparam ppb_pkg::ppb_state_t loc = ppb_pkg::access_local_unblock_state;
   localparam ppb_pkg::ppb_state_t rem = ppb_pkg::access_remote_unblock_state;
   localparam ppb_pkg::ppb_state_t opr = ppb_pkg::access_operational_state;

   // One event per edge; management block wins, then management unblock, then the link.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state    <= blk;
         tx       <= '0;
         mgmt_out <= '0;
         blkreq   <= 1'b0;
      end else begin
         tx       <= '0;
         mgmt_out <= '0;
         blkreq   <= 1'b0;
         if (mgmt_block_command) begin
            tx    <= '{1'b1, ppb_pkg::le_block_cmd_msg};
            state <= blk;
         end else if (mgmt_unblock_request) begin
            tx <= '{1'b1, ppb_pkg::le_unblock_msg};
            if (state == blk) begin
               state <= loc;
            end else if (state == rem) begin
               state                       <= opr;
               mgmt_out.unblock_indication <= 1'b1;
            end
         end else if (rx.valid) begin
            case (rx.code)
               ppb_pkg::an_unblock_msg: begin
                  if (state == blk || state == rem) begin
                     mgmt_out.unblock_request <= 1'b1;
                     state                    <= rem;
                  end else begin
                     mgmt_out.unblock_indication <= 1'b1;
                     state                       <= opr;
                  end
               end
               ppb_pkg::an_block_cmd_msg: begin
                  mgmt_out.block_command <= (state != blk);
                  state                  <= blk;
               end
               ppb_pkg::an_block_request_msg: blkreq <= (state == opr);
               default: ;
            endcase
         end
      end
   end
endmodule : ppb_le_model

`default_nettype wire

// [testbench/test_ppb_an_fsm.sv]
// Self-checking bench for the access-side port FSM against an exchange model.
`timescale 1ns/1ns
`default_nettype none

module test_ppb_an_fsm;
   localparam ppb_pkg::ppb_state_t blk = ppb_pkg::access_blocked_state;
   localparam ppb_pkg::ppb_state_t loc = ppb_pkg::access_local_unblock_state;
   localparam ppb_pkg::ppb_state_t rem = ppb_pkg::access_remote_unblock_state;
   localparam ppb_pkg::ppb_state_t opr = ppb_pkg::access_operational_state;
   localparam logic [3:0]          t_ub = {1'b1, ppb_pkg::CODE_AN_UNBLOCK};
   localparam logic [3:0]          t_bc = {1'b1, ppb_pkg::CODE_AN_BLOCK};
   localparam logic [3:0]          t_br = {1'b1, ppb_pkg::CODE_AN_BLKREQ};

   // Stimulus, observed outputs and counters.
   logic                   clk, rst, ubr, blk_cmd, dbr, le_ubr, le_blk, le_breq, call_blk, oper;
   ppb_pkg::ppb_mgmt_out_t mo, le_mo;
   ppb_pkg::ppb_link_t     a2l, l2a;
   ppb_pkg::ppb_line_t     lin, lout;
   ppb_pkg::ppb_state_t    st, le_st;
   int                     err_total = 0;
   int                     compares = 0;

   ppb_an_fsm DUT (.clk(clk), .rst(rst), .mgmt_unblock_request(ubr),
      .mgmt_block_command(blk_cmd), .mgmt_deferrable_block_request(dbr), .mgmt_out(mo),
      .rx(l2a), .tx(a2l), .line_in(lin), .line_out(lout),
      .access_call_entity_blocked(call_blk), .port_operational(oper), .port_state(st));

   ppb_le_model LE (.clk(clk), .rst(rst), .mgmt_unblock_request(le_ubr),
      .mgmt_block_command(le_blk), .mgmt_out(le_mo), .blkreq(le_breq), .rx(a2l),
      .tx(l2a), .state(le_st));

   // Free-running 10 MHz clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Compares state, link output and management pulses of the block in one go.
   task automatic see(input string w, input ppb_pkg::ppb_state_t s, input logic [3:0] t,
                      input logic [2:0] m);
      chk({w, " state"}, st, s);
      chk({w, " tx"}, a2l, t);
      chk({w, " mgmt"}, mo, m);
   endtask : see

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // Raises one management input for one cycle, returns once its answer is visible.
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: ubr <= 1'b1;
         1: blk_cmd <= 1'b1;
         2: dbr <= 1'b1;
         3: le_ubr <= 1'b1;
         default: le_blk <= 1'b1;
      endcase
      @(posedge clk);
      {ubr, blk_cmd, dbr, le_ubr, le_blk} <= '0;
      #1;
   endtask : pulse

   // Offers one line word and compares what is forwarded a cycle later.
   task automatic send_line(input logic pass);
      @(posedge clk);
      lin <= '{1'b1, 8'h5a};
      @(posedge clk);
      lin <= '0;
      #1;
      chk("line out", lout, pass ? 12'h15a : 12'h000);
   endtask : send_line

   task automatic t_peer_unblock;
      pulse(2);
      see("defer blocked", blk, 0, 0);
      pulse(3);
      step(1);
      see("peer unblock", rem, 0, 3'h4);
      step(20);
      see("remote wait", rem, 0, 0);
      pulse(3);
      step(1);
      see("repeat", rem, 0, 3'h4);
      pulse(0);
      see("agree", opr, t_ub, 3'h2);
      chk("call free", call_blk, 0);
      step(1);
      chk("le ack", {le_st, le_mo}, {opr, 3'h2});
      send_line(1'b1);
      $display("test peer_unblock done");
   endtask : t_peer_unblock

   task automatic t_blkreq;
      pulse(2);
      see("defer", opr, t_br, 0);
      step(1);
      chk("le defer", le_breq, 1);
      pulse(4);
      step(1);
      see("granted", blk, 0, 3'h1);
      chk("call blocked", {call_blk, oper}, 2'b10);
      $display("test blkreq done");
   endtask : t_blkreq

   task automatic t_own_unblock;
      pulse(0);
      see("own unblock", loc, t_ub, 0);
      pulse(0);
      see("resend", loc, t_ub, 0);
      chk("le remote", le_st, rem);
      pulse(3);
      step(1);
      see("ack", opr, 0, 3'h2);
      $display("test own_unblock done");
   endtask : t_own_unblock

   task automatic t_status;
      pulse(0);
      see("status", opr, t_ub, 3'h2);
      pulse(3);
      step(1);
      see("answer", opr, t_ub, 3'h2);
      step(1);
      chk("le confirm", {le_st, le_mo}, {opr, 3'h2});
      $display("test status done");
   endtask : t_status

   task automatic t_block;
      pulse(1);
      see("block", blk, t_bc, 0);
      step(1);
      chk("le blocked", {le_st, le_mo}, {blk, 3'h1});
      pulse(1);
      see("block again", blk, t_bc, 0);
      send_line(1'b0);
      pulse(4);
      step(1);
      see("block in blocked", blk, 0, 0);
      pulse(3);
      step(1);
      see("remote", rem, 0, 3'h4);
      pulse(4);
      step(1);
      see("cancel", blk, 0, 3'h1);
      pulse(0);
      see("unblock again", loc, t_ub, 0);
      send_line(1'b0);
      pulse(1);
      see("block local", blk, t_bc, 0);
      step(1);
      chk("le cancel", {le_st, le_mo}, {blk, 3'h1});
      $display("test block done");
   endtask : t_block

   // Several management inputs in one cycle: only the highest-ranked one is taken.
   task automatic t_order;
      @(posedge clk);
      {ubr, blk_cmd, dbr} <= 3'h7;
      @(posedge clk);
      {ubr, blk_cmd, dbr} <= 3'h0;
      #1;
      see("block first", blk, t_bc, 0);
      @(posedge clk);
      {ubr, dbr} <= 2'h3;
      @(posedge clk);
      {ubr, dbr} <= 2'h0;
      #1;
      see("unblock first", loc, t_ub, 0);
      $display("test order done");
   endtask : t_order

   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   // Main sequence: reset for eight cycles, then every scenario in turn.
   initial begin
      rst = 1'b1;
      {ubr, blk_cmd, dbr, le_ubr, le_blk} = '0;
      lin = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      step(1);
      see("reset", blk, 0, 0);
      chk("reset call", {call_blk, oper}, 2'b10);
      t_peer_unblock();
      t_blkreq();
      t_own_unblock();
      t_status();
      t_block();
      t_order();
      summarize();
   end

   // Watchdog far beyond the fewer than a hundred cycles the scenarios need.
   initial begin
      repeat (2000) @(posedge clk);
      err_total++;
      $display("mismatch watchdog expected finish seen timeout");
      summarize();
   end
endmodule : test_ppb_an_fsm

`default_nettype wire
